// File: pkg/vpsc_consts.vh
// register map, field positions, reset values and timing for the voltage command block
`ifndef VPSC_CONSTS_VH
`define VPSC_CONSTS_VH

// ------------------------------
// register offsets (word index on the plain port)
// ------------------------------
`define VPSC_ADDR_CMD        4'h0
`define VPSC_ADDR_SETPOINT   4'h1
`define VPSC_ADDR_CEILING    4'h2
`define VPSC_ADDR_TRIPLVL    4'h3
`define VPSC_ADDR_PENDTRIG   4'h4
`define VPSC_ADDR_RUNMODE    4'h5
`define VPSC_ADDR_COND       4'h6
`define VPSC_ADDR_MASK       4'h7
`define VPSC_ADDR_EVENT      4'h8
`define VPSC_ADDR_ERROR      4'h9
`define VPSC_ADDR_TRIPMAX    4'hA
`define VPSC_ADDR_TRIPMIN    4'hB
`define VPSC_ADDR_SETMIN     4'hC
`define VPSC_ADDR_STATUS     4'hD
`define VPSC_ADDR_STEPDAT    4'hE

// ------------------------------
// command register codes
// ------------------------------
`define VPSC_CMD_FIXED       4'h1
`define VPSC_CMD_SEQRUN      4'h2
`define VPSC_CMD_TRIGGER     4'h3
`define VPSC_CMD_SEQCLEAR    4'h4
`define VPSC_CMD_BRKRESET    4'h5

// ------------------------------
// answer keywords
// ------------------------------
`define VPSC_KW_FIXED        2'h0
`define VPSC_KW_SEQRUN       2'h1
`define VPSC_KW_VOLTAGE_SETPOINT         2'h0
`define VPSC_KW_CURR         2'h1

// ------------------------------
// operating condition bit map
// ------------------------------
`define VPSC_BIT_CAL         0
`define VPSC_BIT_WTG         5
`define VPSC_BIT_CV          8
`define VPSC_BIT_CC          10
`define VPSC_COND_USED       16'h0521

// ------------------------------
// error codes (two's complement, 16 bit)
// ------------------------------
`define VPSC_ERR_NONE        16'h0000
`define VPSC_ERR_RANGE       16'hFF22
`define VPSC_ERR_CMD         16'hFF9F

// ------------------------------
// reset values and timing
// ------------------------------
`define VPSC_RST_CEILING     16'hFFFF
`define VPSC_RST_TRIPLVL     16'hFFFF
`define VPSC_STEP_TIME_NS    1000
`define VPSC_CLK_PERIOD_NS   8
`define VPSC_STEP_CYCLES     (`VPSC_STEP_TIME_NS / `VPSC_CLK_PERIOD_NS)

`endif

// File: hdl/vpsc_seq_store.v
// step memory that holds the stored voltage sequence
`timescale 1ns/1ns
`default_nettype none

module vpsc_seq_store #(
    parameter DATA_W  = 16,
    parameter DEPTH_W = 3
) (
    input  wire               ref_clk,
    input  wire               ce,
    input  wire               wr_en,
    input  wire [DEPTH_W-1:0] wr_idx,
    input  wire [DATA_W-1:0]  wr_data,
    input  wire [DEPTH_W-1:0] rd_idx,
    output reg  [DATA_W-1:0]  rd_data
);

    reg [DATA_W-1:0] step_mem [0:(1<<DEPTH_W)-1];

    // --------------------------
    // write port and registered read port
    // --------------------------
    // no reset on the array: contents are only meaningful once written
    always @(posedge ref_clk) begin
        if (ce) begin
            if (wr_en) begin
                step_mem[wr_idx] <= wr_data;
            end
            rd_data <= step_mem[rd_idx];
        end
    end

endmodule // vpsc_seq_store
`default_nettype wire

// File: hdl/vpsc_cmp_le.v
// registered greater-than compare used for the trip detector
`timescale 1ns/1ns
`default_nettype none

module vpsc_cmp_le #(
    parameter W = 16
) (
    input  wire         ref_clk,
    input  wire         reset,
    input  wire         ce,
    input  wire [W-1:0] a,
    input  wire [W-1:0] b,
    output reg          a_above_b
);

    // --------------------------
    // compare is registered so the trip path meets timing at 125 MHz
    // --------------------------
    always @(posedge ref_clk) begin
        if (reset) begin
            a_above_b <= 1'b0;
        end else if (ce) begin
            a_above_b <= (a > b);
        end
    end

endmodule // vpsc_cmp_le
`default_nettype wire

// File: hdl/vpsc_voltage_cmds.v
// voltage command and operating status register block
//
// How it works
// - ceiling read returns the last ceiling value software stored.
// - after reset the block is in fixed mode and accepts step writes.
// - sequence-run start executes steps; step writes then raise a command error.
// - fixed command during a run aborts and restores the pre-run setpoint.
// - a completed run leaves the last step's setpoint in force.
// - run-mode read shows sequence keyword while running, fixed keyword otherwise.
// - trip level above factory maximum is rejected with error -222.
// - output above the trip level opens the breaker and shuts output down.
// - trip reads give stored level, factory maximum, or zero minimum.
// - pending trigger value is applied on trigger; above ceiling gives -222.
// - pending trigger read returns the stored pending value.
// - regulation read returns voltage or current keyword per regulation state.
// - setpoint above ceiling is not applied and error -222 is queued.
// - setpoint minimum read always returns zero.
// - condition register is live, unlatched, within 0 to 1313.
// - bit 0 shows calibration busy, bit 5 waiting for trigger.
// - bit 8 constant voltage, bit 10 constant current, others unused.
// - ceiling above stored trip level is rejected with error -222.
// - event register latches every event and clears when read.
//
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "vpsc_consts.vh"

module vpsc_voltage_cmds #(
    parameter DATA_W      = 16,
    parameter DEPTH_W     = 3,
    parameter TRIP_MAX    = 16'hF000,
    parameter STEP_CYCLES = `VPSC_STEP_CYCLES
) (
    input  wire              ref_clk,
    input  wire              reset,
    input  wire              ce,
    input  wire [3:0]        addr,
    input  wire [15:0]       wdata,
    input  wire              wr_stb,
    input  wire              rd_stb,
    output reg  [15:0]       rdata,
    input  wire [DATA_W-1:0] output_monitor,
    input  wire              calibrating,
    input  wire              waiting_for_trigger_flag,
    input  wire              constant_voltage_flag,
    input  wire              constant_current_flag,
    output reg  [DATA_W-1:0] voltage_out,
    output reg               breaker_open,
    output reg               seq_running,
    output reg               err_pulse
);

    // --------------------------
    // states of the sequence runner
    // --------------------------
    localparam ST_FIXED = 2'b01;
    localparam ST_RUN   = 2'b10;

    reg [1:0]         state_reg;
    reg [1:0]         state_next;
    reg [DATA_W-1:0]  setpoint_reg;
    reg [DATA_W-1:0]  saved_reg;
    reg [DATA_W-1:0]  ceiling_reg;
    reg [DATA_W-1:0]  trip_reg;
    reg [DATA_W-1:0]  pending_reg;
    reg [15:0]        mask_reg;
    reg [15:0]        event_reg;
    reg [15:0]        cond_prev_reg;
    reg [15:0]        error_reg;
    reg [DEPTH_W-1:0] step_cnt_reg;
    reg [DEPTH_W-1:0] step_idx_reg;
    reg [DEPTH_W:0]   step_len_reg;
    reg [31:0]        dwell_reg;
    reg               load_pend_reg;

    wire [15:0]        cond_live;
    wire [DATA_W-1:0]  step_data;
    wire               over_trip;
    wire               wr_cmd;
    wire               is_run;
    wire               last_step;
    wire               dwell_done;

    assign is_run     = state_reg[1];
    assign wr_cmd     = wr_stb && (addr == `VPSC_ADDR_CMD);
    assign last_step  = ({1'b0, step_idx_reg} + 1'b1) >= step_len_reg;
    assign dwell_done = (dwell_reg == 32'h0);

    // --------------------------
    // live condition word
    // --------------------------
    // live unlatched bits
    assign cond_live = ((16'h0001 << `VPSC_BIT_CAL) & {16{calibrating}})
                     | ((16'h0001 << `VPSC_BIT_WTG) & {16{waiting_for_trigger_flag}})
                     | ((16'h0001 << `VPSC_BIT_CV)  & {16{constant_voltage_flag}})
                     | ((16'h0001 << `VPSC_BIT_CC)  & {16{constant_current_flag}});

    // --------------------------
    // sub blocks
    // --------------------------
    vpsc_seq_store #(
        .DATA_W  (DATA_W),
        .DEPTH_W (DEPTH_W)
    ) u_store (
        .ref_clk (ref_clk),
        .ce      (ce),
        .wr_en   (wr_stb && (addr == `VPSC_ADDR_STEPDAT) && !is_run && !step_len_reg[DEPTH_W]),
        .wr_idx  (step_cnt_reg),
        .wr_data (wdata[DATA_W-1:0]),
        .rd_idx  (step_idx_reg),
        .rd_data (step_data)
    );

    vpsc_cmp_le #(
        .W (DATA_W)
    ) u_trip (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .ce        (ce),
        .a         (output_monitor),
        .b         (trip_reg),
        .a_above_b (over_trip)
    );

    // --------------------------
    // sequence state decode
    // --------------------------
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_FIXED: begin
                if (wr_cmd && wdata[3:0] == `VPSC_CMD_SEQRUN && step_len_reg != 0) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (wr_cmd && wdata[3:0] == `VPSC_CMD_FIXED) begin
                    state_next = ST_FIXED;
                end else if (dwell_done && last_step && !load_pend_reg) begin
                    state_next = ST_FIXED;
                end
            end
            default: state_next = ST_FIXED;
        endcase
    end

    // --------------------------
    // settings, sequence runner and error queue entry
    // --------------------------
    always @(posedge ref_clk) begin
        if (reset) begin
            state_reg     <= ST_FIXED;
            setpoint_reg  <= {DATA_W{1'b0}};
            saved_reg     <= {DATA_W{1'b0}};
            ceiling_reg   <= `VPSC_RST_CEILING;
            trip_reg      <= `VPSC_RST_TRIPLVL;
            pending_reg   <= {DATA_W{1'b0}};
            mask_reg      <= 16'h0000;
            error_reg     <= `VPSC_ERR_NONE;
            step_cnt_reg  <= {DEPTH_W{1'b0}};
            step_idx_reg  <= {DEPTH_W{1'b0}};
            step_len_reg  <= {(DEPTH_W+1){1'b0}};
            dwell_reg     <= 32'h0;
            load_pend_reg <= 1'b0;
            breaker_open  <= 1'b0;
            err_pulse     <= 1'b0;
        end else if (ce) begin
            state_reg <= state_next;
            err_pulse <= 1'b0;
            if (over_trip) begin
                breaker_open <= 1'b1;
            end
            // step load: the store answers a cycle after the index moves,
            // so a one-cycle dwell comes before each load
            if (is_run && !dwell_done) begin
                dwell_reg <= dwell_reg - 32'h1;
            end else if (is_run && load_pend_reg) begin
                // each step writes the setpoint, last one stays
                setpoint_reg  <= step_data;
                load_pend_reg <= 1'b0;
                dwell_reg     <= STEP_CYCLES;
            end else if (is_run && !last_step) begin
                step_idx_reg  <= step_idx_reg + 1'b1;
                load_pend_reg <= 1'b1;
                dwell_reg     <= 32'h1;
            end
            if (wr_stb) begin
                case (addr)
                    `VPSC_ADDR_SETPOINT: begin
                        if (wdata[DATA_W-1:0] > ceiling_reg) begin
                            error_reg <= `VPSC_ERR_RANGE;
                            err_pulse <= 1'b1;
                        end else begin
                            setpoint_reg <= wdata[DATA_W-1:0];
                        end
                    end
                    `VPSC_ADDR_CEILING: begin
                        if (wdata[DATA_W-1:0] > trip_reg) begin
                            error_reg <= `VPSC_ERR_RANGE;
                            err_pulse <= 1'b1;
                        end else begin
                            ceiling_reg <= wdata[DATA_W-1:0];
                        end
                    end
                    `VPSC_ADDR_TRIPLVL: begin
                        if (wdata[DATA_W-1:0] > TRIP_MAX) begin
                            error_reg <= `VPSC_ERR_RANGE;
                            err_pulse <= 1'b1;
                        end else begin
                            trip_reg <= wdata[DATA_W-1:0];
                        end
                    end
                    `VPSC_ADDR_PENDTRIG: begin
                        if (wdata[DATA_W-1:0] > ceiling_reg) begin
                            error_reg <= `VPSC_ERR_RANGE;
                            err_pulse <= 1'b1;
                        end else begin
                            pending_reg <= wdata[DATA_W-1:0];
                        end
                    end
                    `VPSC_ADDR_MASK: begin
                        mask_reg <= wdata & `VPSC_COND_USED;
                    end
                    `VPSC_ADDR_STEPDAT: begin
                        if (is_run) begin
                            error_reg <= `VPSC_ERR_CMD;
                            err_pulse <= 1'b1;
                        end else if (step_len_reg != (1 << DEPTH_W)) begin
                            step_cnt_reg <= step_cnt_reg + 1'b1;
                            step_len_reg <= step_len_reg + 1'b1;
                        end
                    end
                    `VPSC_ADDR_CMD: begin
                        case (wdata[3:0])
                            `VPSC_CMD_SEQRUN: begin
                                if (!is_run && step_len_reg != 0) begin
                                    saved_reg     <= setpoint_reg;
                                    step_idx_reg  <= {DEPTH_W{1'b0}};
                                    load_pend_reg <= 1'b1;
                                    dwell_reg     <= 32'h1;
                                end
                            end
                            `VPSC_CMD_FIXED: begin
                                if (is_run) begin
                                    setpoint_reg  <= saved_reg;
                                    load_pend_reg <= 1'b0;
                                    dwell_reg     <= 32'h0;
                                end
                            end
                            `VPSC_CMD_TRIGGER: begin
                                setpoint_reg <= pending_reg;
                            end
                            `VPSC_CMD_SEQCLEAR: begin
                                // clearing is a step command too
                                if (is_run) begin
                                    error_reg <= `VPSC_ERR_CMD;
                                    err_pulse <= 1'b1;
                                end else begin
                                    step_cnt_reg <= {DEPTH_W{1'b0}};
                                    step_len_reg <= {(DEPTH_W+1){1'b0}};
                                end
                            end
                            `VPSC_CMD_BRKRESET: begin
                                // a trip in the same cycle wins over the reset
                                breaker_open <= over_trip;
                            end
                            default: begin
                                error_reg <= `VPSC_ERR_CMD;
                                err_pulse <= 1'b1;
                            end
                        endcase
                    end
                    default: begin
                    end
                endcase
            end else if (rd_stb && addr == `VPSC_ADDR_ERROR) begin
                // reading the error entry empties it, unless a write strobe comes in the same cycle
                error_reg <= `VPSC_ERR_NONE;
            end
        end
    end

    // --------------------------
    // event latch: rising condition bits, set wins over read clear
    // --------------------------
    always @(posedge ref_clk) begin
        if (reset) begin
            event_reg     <= 16'h0000;
            // prime the detector with live bits, so reset makes no false event
            cond_prev_reg <= cond_live;
        end else if (ce) begin
            cond_prev_reg <= cond_live;
            if (rd_stb && addr == `VPSC_ADDR_EVENT) begin
                event_reg <= cond_live & ~cond_prev_reg;
            end else begin
                event_reg <= event_reg | (cond_live & ~cond_prev_reg);
            end
        end
    end

    // --------------------------
    // outputs and read mux
    // --------------------------
    always @(posedge ref_clk) begin
        if (reset) begin
            rdata       <= 16'h0000;
            voltage_out <= {DATA_W{1'b0}};
            seq_running <= 1'b0;
        end else if (ce) begin
            // shut down while the breaker is open
            voltage_out <= breaker_open ? {DATA_W{1'b0}} : setpoint_reg;
            seq_running <= state_next[1];
            rdata       <= 16'h0000;
            if (rd_stb) begin
                case (addr)
                    `VPSC_ADDR_SETPOINT: rdata <= setpoint_reg;
                    `VPSC_ADDR_CEILING:  rdata <= ceiling_reg;
                    // stored, maximum and minimum trip level
                    `VPSC_ADDR_TRIPLVL:  rdata <= trip_reg;
                    `VPSC_ADDR_TRIPMAX:  rdata <= TRIP_MAX;
                    `VPSC_ADDR_TRIPMIN:  rdata <= 16'h0000;
                    `VPSC_ADDR_SETMIN:   rdata <= 16'h0000;
                    `VPSC_ADDR_PENDTRIG: rdata <= pending_reg;
                    `VPSC_ADDR_RUNMODE:  rdata <= {14'h0000,
                                             is_run ? `VPSC_KW_SEQRUN : `VPSC_KW_FIXED};
                    // regulation keyword in low bits, breaker in bit 15
                    `VPSC_ADDR_STATUS:   rdata <= {breaker_open, 13'h0000,
                                             constant_current_flag ? `VPSC_KW_CURR
                                                                   : `VPSC_KW_VOLTAGE_SETPOINT};
                    `VPSC_ADDR_COND:     rdata <= cond_live;
                    `VPSC_ADDR_MASK:     rdata <= mask_reg;
                    `VPSC_ADDR_EVENT:    rdata <= event_reg;
                    `VPSC_ADDR_ERROR:    rdata <= error_reg;
                    default:             rdata <= 16'h0000;
                endcase
            end
        end
    end

endmodule // vpsc_voltage_cmds
`default_nettype wire

// File: sim/vpsc_monitor.sv
// port-level checks for the voltage command block
`timescale 1ns/1ns
`default_nettype none
`include "vpsc_consts.vh"
module vpsc_monitor #(parameter DATA_W = 16) (
    input wire logic              ref_clk,
    input wire logic              reset,
    input wire logic              ce,
    input wire logic [3:0]        addr,
    input wire logic [15:0]       wdata,
    input wire logic              wr_stb,
    input wire logic              rd_stb,
    input wire logic [15:0]       rdata,
    input wire logic              calibrating,
    input wire logic              waiting_for_trigger_flag,
    input wire logic              constant_voltage_flag,
    input wire logic              constant_current_flag,
    input wire logic [DATA_W-1:0] voltage_out,
    input wire logic              breaker_open,
    input wire logic              seq_running,
    input wire logic              err_pulse
);
    // --------------------------
    // checks
    // --------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    // strobes count only with ce high
    wire logic rd_go = rd_stb & ce;
    wire logic cmd_go = wr_stb & ce & (addr == `VPSC_ADDR_CMD);
    chk_brk_out_zero: assert property (
        breaker_open && $past(breaker_open) |-> voltage_out == '0) else $error("output on");
    chk_brk_latched: assert property (
        breaker_open && ce && !(cmd_go && wdata[3:0] == `VPSC_CMD_BRKRESET) |=> breaker_open)
        else $error("breaker dropped");
    chk_err_from_wr: assert property (
        err_pulse && $past(ce) |-> $past(wr_stb)) else $error("error without write");
    chk_run_start: assert property (
        $rose(seq_running) |-> $past(cmd_go && wdata[3:0] == `VPSC_CMD_SEQRUN))
        else $error("run without command");
    chk_step_refused: assert property (
        wr_stb && ce && addr == `VPSC_ADDR_STEPDAT && seq_running |=> err_pulse)
        else $error("step write taken");
    chk_abort_stop: assert property (
        cmd_go && wdata[3:0] == `VPSC_CMD_FIXED |=> !seq_running) else $error("abort ignored");
    chk_trip_min: assert property (
        rd_go && addr == `VPSC_ADDR_TRIPMIN |=> rdata == 16'h0000) else $error("trip min");
    chk_set_min: assert property (
        rd_go && addr == `VPSC_ADDR_SETMIN |=> rdata == 16'h0000) else $error("set min");
    chk_cond_live: assert property (
        rd_go && addr == `VPSC_ADDR_COND |=> rdata == {5'h00, $past(constant_current_flag),
        1'b0, $past(constant_voltage_flag), 2'h0, $past(waiting_for_trigger_flag), 4'h0,
        $past(calibrating)}) else $error("condition map");
    chk_mode_read: assert property (
        rd_go && addr == `VPSC_ADDR_RUNMODE |=> rdata == {15'h0000, $past(seq_running)})
        else $error("run mode read");
    chk_reg_read: assert property (
        rd_go && addr == `VPSC_ADDR_STATUS |=> rdata[0] == $past(constant_current_flag))
        else $error("regulation read");
    cov_trip: cover property ($rose(breaker_open));
    cov_run_end: cover property ($fell(seq_running));
    cov_err: cover property (err_pulse);
endmodule // vpsc_monitor
bind vpsc_voltage_cmds vpsc_monitor #(.DATA_W(DATA_W)) u_vpsc_monitor (
    .ref_clk(ref_clk), .reset(reset), .ce(ce), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .calibrating(calibrating),
    .waiting_for_trigger_flag(waiting_for_trigger_flag),
    .constant_voltage_flag(constant_voltage_flag), .constant_current_flag(constant_current_flag),
    .voltage_out(voltage_out), .breaker_open(breaker_open), .seq_running(seq_running),
    .err_pulse(err_pulse));
`default_nettype wire

// File: sim/vpsc_output_stage.sv
// power stage model: measured level and regulation flags fed back
`timescale 1ns/1ns
`default_nettype none
module vpsc_output_stage (
    input wire logic        ref_clk,
    input wire logic [15:0] voltage_out,
    input wire logic        breaker_open,
    input wire logic [15:0] overshoot,
    input wire logic        heavy_load,
    output logic     [15:0] output_monitor,
    output logic            constant_voltage_flag,
    output logic            constant_current_flag
);
    // one cycle of lag; an open breaker kills output
    always @(posedge ref_clk) begin
        output_monitor <= breaker_open ? 16'h0000 : voltage_out + overshoot;
        constant_current_flag <= heavy_load & ~breaker_open;
        constant_voltage_flag <= ~heavy_load & ~breaker_open;
    end
endmodule // vpsc_output_stage
`default_nettype wire

// File: sim/test_vpsc_voltage_cmds.sv
// self-checking bench for the voltage command block
`timescale 1ns/1ns
`default_nettype none
`include "vpsc_consts.vh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("[ERR] %s expected %h seen %h", n, e, g); end end
module test_vpsc_voltage_cmds;
    localparam logic [15:0] TRIP_MAX = 16'hF000;
    logic        ref_clk = 1'b0, reset = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0, heavy_load = 1'b0;
    logic        calibrating = 1'b0, waiting_for_trigger_flag = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000, overshoot = 16'h0000;
    wire  [15:0] rdata, voltage_out, output_monitor;
    wire         breaker_open, seq_running, err_pulse, cv_flag, cc_flag;
    int          bad_count = 0, total_checks = 0;
    always #4 ref_clk = ~ref_clk;
    vpsc_voltage_cmds #(.TRIP_MAX(TRIP_MAX), .STEP_CYCLES(8)) u_vpsc_voltage_cmds (
        .ref_clk(ref_clk), .reset(reset), .ce(1'b1), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .output_monitor(output_monitor),
        .calibrating(calibrating), .waiting_for_trigger_flag(waiting_for_trigger_flag),
        .constant_voltage_flag(cv_flag), .constant_current_flag(cc_flag),
        .voltage_out(voltage_out), .breaker_open(breaker_open), .seq_running(seq_running),
        .err_pulse(err_pulse));
    vpsc_output_stage u_vpsc_output_stage (
        .ref_clk(ref_clk), .voltage_out(voltage_out), .breaker_open(breaker_open),
        .overshoot(overshoot), .heavy_load(heavy_load), .output_monitor(output_monitor),
        .constant_voltage_flag(cv_flag), .constant_current_flag(cc_flag));
    // --------------------------
    // register port tasks
    // --------------------------
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
    endtask
    // read data stands one cycle only
    task automatic rd(input logic [3:0] a, input logic [15:0] e, input string n,
                      input logic [15:0] m = 16'hFFFF);
        @(posedge ref_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
        #1;
        `CHK(n, e, rdata & m)
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while (seq_running !== 1'b0 && n < 200) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (n == 200) begin
            bad_count++;
            test_done();
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // hang guard
    initial begin
        #200000;
        bad_count++;
        test_done();
    end
    initial begin
        repeat (5) @(posedge ref_clk);
        reset <= 1'b0;
        rd(`VPSC_ADDR_CEILING, 16'hFFFF, "ceiling");
        rd(`VPSC_ADDR_RUNMODE, {14'h0, `VPSC_KW_FIXED}, "mode");
        rd(`VPSC_ADDR_TRIPMAX, TRIP_MAX, "tripmax");
        rd(`VPSC_ADDR_TRIPMIN, 16'h0000, "tripmin");
        rd(`VPSC_ADDR_SETMIN, 16'h0000, "setmin");
        wr(`VPSC_ADDR_TRIPLVL, TRIP_MAX + 16'h0001);
        rd(`VPSC_ADDR_ERROR, `VPSC_ERR_RANGE, "err");
        rd(`VPSC_ADDR_TRIPLVL, 16'hFFFF, "trip");
        wr(`VPSC_ADDR_TRIPLVL, 16'h0800);
        wr(`VPSC_ADDR_CEILING, 16'h0801);
        rd(`VPSC_ADDR_ERROR, `VPSC_ERR_RANGE, "err");
        wr(`VPSC_ADDR_CEILING, 16'h0400);
        rd(`VPSC_ADDR_CEILING, 16'h0400, "ceiling");
        wr(`VPSC_ADDR_SETPOINT, 16'h0300);
        wr(`VPSC_ADDR_SETPOINT, 16'h0401);
        rd(`VPSC_ADDR_ERROR, `VPSC_ERR_RANGE, "err");
        rd(`VPSC_ADDR_SETPOINT, 16'h0300, "setpoint");
        wr(`VPSC_ADDR_PENDTRIG, 16'h0401);
        rd(`VPSC_ADDR_ERROR, `VPSC_ERR_RANGE, "err");
        wr(`VPSC_ADDR_PENDTRIG, 16'h0400);
        rd(`VPSC_ADDR_PENDTRIG, 16'h0400, "pending");
        `CHK("vout", 16'h0300, voltage_out)
        wr(`VPSC_ADDR_CMD, {12'h000, `VPSC_CMD_TRIGGER});
        rd(`VPSC_ADDR_ERROR, 16'h0000, "err");
        `CHK("vout", 16'h0400, voltage_out)
        wr(`VPSC_ADDR_MASK, 16'hFFFF);
        rd(`VPSC_ADDR_MASK, `VPSC_COND_USED, "mask");
        // step write while running is refused
        wr(`VPSC_ADDR_STEPDAT, 16'h0100);
        wr(`VPSC_ADDR_STEPDAT, 16'h0150);
        wr(`VPSC_ADDR_CMD, {12'h000, `VPSC_CMD_SEQRUN});
        rd(`VPSC_ADDR_RUNMODE, {14'h0, `VPSC_KW_SEQRUN}, "mode");
        wr(`VPSC_ADDR_STEPDAT, 16'h0200);
        rd(`VPSC_ADDR_ERROR, `VPSC_ERR_CMD, "err");
        wait_idle();
        rd(`VPSC_ADDR_RUNMODE, {14'h0, `VPSC_KW_FIXED}, "mode");
        `CHK("vout", 16'h0150, voltage_out)
        wr(`VPSC_ADDR_SETPOINT, 16'h0300);
        wr(`VPSC_ADDR_CMD, {12'h000, `VPSC_CMD_SEQRUN});
        wr(`VPSC_ADDR_CMD, {12'h000, `VPSC_CMD_FIXED});
        rd(`VPSC_ADDR_RUNMODE, {14'h0, `VPSC_KW_FIXED}, "mode");
        `CHK("vout", 16'h0300, voltage_out)
        // drain events
        rd(`VPSC_ADDR_EVENT, 16'h0000, "event", ~`VPSC_COND_USED);
        @(posedge ref_clk);
        calibrating <= 1'b1;
        waiting_for_trigger_flag <= 1'b1;
        heavy_load <= 1'b1;
        rd(`VPSC_ADDR_COND, 16'h0421, "cond");
        rd(`VPSC_ADDR_EVENT, 16'h0421, "event");
        rd(`VPSC_ADDR_EVENT, 16'h0000, "event");
        rd(`VPSC_ADDR_STATUS, 16'h0001, "status");
        @(posedge ref_clk);
        heavy_load <= 1'b0;
        overshoot <= 16'h0600;
        repeat (6) @(posedge ref_clk);
        #1;
        `CHK("breaker", 1'b1, breaker_open)
        `CHK("vout", 16'h0000, voltage_out)
        wr(`VPSC_ADDR_CMD, {12'h000, `VPSC_CMD_BRKRESET});
        rd(`VPSC_ADDR_STATUS, 16'h0000, "status", 16'h8000);
        test_done();
    end
endmodule // test_vpsc_voltage_cmds
`default_nettype wire
